// file: hdl/sbcct_pkg.sv
// Package: constants and carrier types for the 16-bit capture/compare timer
package sbcct_pkg;

	// ==========================================
	// Widths and reset values
	localparam int CNT_W = 16;
	localparam logic [15:0] CNT_RESET = 16'h0000;
	localparam logic [15:0] CNT_MAX = 16'hFFFF;
	localparam int FILT_SAMPLES = 4;
	localparam logic [2:0] FILT_LAST = 3'h3;

	// ==========================================
	// Clock source select codes
	localparam logic [2:0] CS_BASE = 3'h0;
	localparam logic [2:0] CS_IO = 3'h1;
	localparam logic [2:0] CS_T0 = 3'h2;
	localparam logic [2:0] CS_T1 = 3'h3;
	localparam logic [2:0] CS_T2 = 3'h4;
	localparam logic [2:0] CS_EXTA = 3'h5;
	localparam logic [2:0] CS_EXTB = 3'h6;
	localparam logic [2:0] CS_OSC = 3'h7;

	// ==========================================
	// Capture source and edge codes
	localparam logic [1:0] ICS_PIN = 2'h0;
	localparam logic [1:0] ICS_LF = 2'h1;
	localparam logic [1:0] ICS_T1 = 2'h2;
	localparam logic [1:0] ICS_T2 = 2'h3;
	localparam logic [1:0] EDGE_OFF = 2'h0;
	localparam logic [1:0] EDGE_RISE = 2'h1;
	localparam logic [1:0] EDGE_FALL = 2'h2;
	localparam logic [1:0] EDGE_BOTH = 2'h3;

	// ==========================================
	// Byte access register selects
	localparam logic [1:0] SEL_CMP_A = 2'h0;
	localparam logic [1:0] SEL_CMP_B = 2'h1;
	localparam logic [1:0] SEL_CAP = 2'h2;

	// ==========================================
	// Flag bit positions
	localparam int IRQ_OVF = 0;
	localparam int IRQ_MA = 1;
	localparam int IRQ_MB = 2;
	localparam int IRQ_CAP = 3;

	typedef struct packed {
		logic enable;
		logic toggle_on_start;
		logic counter_reset;
		logic alt_compare_en;
	} sbcct_ctrl_t;

	typedef struct packed {
		logic capture_reset_mask;
		logic reset_mask_b;
		logic single_mask_b;
		logic toggle_mask_b;
		logic reset_mask_a;
		logic single_mask_a;
		logic toggle_mask_a;
	} sbcct_action_t;

	typedef struct packed {
		logic [1:0] cap_sel;
		logic filter_en;
		logic [1:0] edge_sel;
		logic [2:0] clk_sel;
	} sbcct_mode_t;

	typedef enum logic [2:0] {
		SM_IDLE = 3'b001,
		SM_ARMED = 3'b010,
		SM_RUN = 3'b100
	} sbcct_sensor_state_t;

endpackage : sbcct_pkg

// file: hdl/sbcct_filter.sv
// Module: capture input noise filter with edge detect
module sbcct_filter (
	input wire logic clock_in,
	input wire logic reset_in,
	input wire logic enable_in,
	input wire logic tick_in,
	input wire logic filter_en_in,
	input wire logic [1:0] edge_sel_in,
	input wire logic sample_in,
	output logic event_out
);

	logic [2:0] run_reg;
	logic last_reg;
	logic level_reg;
	logic prev_reg;
	logic level_next;

	// ==========================================
	// Filter: output follows after four equal samples
	always_ff @(posedge clock_in)
	begin
		if (reset_in)
		begin
			run_reg <= 3'h0;
			last_reg <= 1'b0;
			level_reg <= 1'b0;
		end
		else if (enable_in && tick_in)
		begin
			last_reg <= sample_in;
			if (sample_in != last_reg)
				run_reg <= 3'h0;
			else if (run_reg != sbcct_pkg::FILT_LAST)
				run_reg <= run_reg + 3'h1;
			if (!filter_en_in)
				level_reg <= sample_in;
			else if (sample_in == last_reg && run_reg == 3'(sbcct_pkg::FILT_LAST - 3'h1))
				level_reg <= sample_in;
		end
	end

	assign level_next = level_reg;

	// ==========================================
	// Edge detect on filtered level
	always_ff @(posedge clock_in)
	begin
		if (reset_in)
		begin
			prev_reg <= 1'b0;
			event_out <= 1'b0;
		end
		else if (enable_in)
		begin
			prev_reg <= level_next;
			case (edge_sel_in)
				sbcct_pkg::EDGE_RISE: event_out <= level_next & ~prev_reg;
				sbcct_pkg::EDGE_FALL: event_out <= ~level_next & prev_reg;
				sbcct_pkg::EDGE_BOTH: event_out <= level_next ^ prev_reg;
				default: event_out <= 1'b0;
			endcase
		end
	end

endmodule : sbcct_filter

// file: hdl/sbcct_timer.sv
// Module: 16-bit capture/compare timer core
module sbcct_timer (
	input wire logic clock_in,
	input wire logic reset_in,
	input wire logic clk_en_in,
	input wire sbcct_pkg::sbcct_ctrl_t ctrl_in,
	input wire sbcct_pkg::sbcct_action_t action_in,
	input wire sbcct_pkg::sbcct_mode_t mode_in,
	input wire logic modulator_en_in,
	input wire logic [3:0] irq_mask_reg_in,
	input wire logic [3:0] irq_clear_in,
	input wire logic sw_capture_set_in,
	input wire logic byte_wr_in,
	input wire logic byte_rd_in,
	input wire logic byte_hi_in,
	input wire logic [1:0] byte_sel_in,
	input wire logic [7:0] byte_wdata_in,
	input wire logic io_clk,
	input wire logic ext_clk_in_a,
	input wire logic ext_clk_in_b,
	input wire logic timer_zero_stage_clk,
	input wire logic timer_one_stage_clk,
	input wire logic timer_two_stage_clk,
	input wire logic rc_osc_out,
	input wire logic timer_base_clk,
	input wire logic ext_capture_pin,
	input wire logic lf_rx_data_out,
	input wire logic sensor_meas_start_in,
	input wire logic neighbour_match_in,
	output logic [7:0] byte_rdata_out,
	output logic [15:0] counter_value_out,
	output logic sw_capture_req_out,
	output logic [3:0] irq_flag_reg_out,
	output logic capture_irq_out,
	output logic overflow_irq_out,
	output logic match_a_irq_out,
	output logic match_b_irq_out,
	output logic modulator_out_pin_out,
	output logic own_stage_clk_out,
	output logic sensor_busy_out
);

	logic [7:0] src_s1_reg;
	logic [7:0] src_s2_reg;
	logic [7:0] src_s3_reg;
	logic [2:0] cap_s1_reg;
	logic [2:0] cap_s2_reg;
	logic [2:0] cap_s3_reg;
	logic [7:0] src_level;
	logic [15:0] cmp_a_reg;
	logic [15:0] cmp_b_reg;
	logic [15:0] capture_reg;
	logic [7:0] hi_stage_reg;
	logic [7:0] hi_latch_reg;
	logic sel_s2;
	logic sel_s3;
	logic tick;
	logic cap_raw;
	logic cap_edge;
	logic capture_evt;
	logic match_a_sig;
	logic match_b_sig;
	logic alt_turn_reg;
	logic single_a_done_reg;
	logic single_b_done_reg;
	logic fire_a;
	logic fire_b;
	logic capture_reset_sig;
	logic wrap;
	logic enable_prev_reg;
	logic start_pulse;
	sbcct_pkg::sbcct_sensor_state_t sm_reg;

	// ==========================================
	// Input synchronisers, three stages each
	// Clock sources are sampled, not used as clocks: one clock domain only
	always_ff @(posedge clock_in)
	begin
		if (reset_in)
		begin
			src_s1_reg <= 8'h00;
			src_s2_reg <= 8'h00;
			src_s3_reg <= 8'h00;
			cap_s1_reg <= 3'h0;
			cap_s2_reg <= 3'h0;
			cap_s3_reg <= 3'h0;
		end
		else if (clk_en_in)
		begin
			src_s1_reg <= {rc_osc_out, ext_clk_in_b, ext_clk_in_a, timer_two_stage_clk,
				timer_one_stage_clk, timer_zero_stage_clk, io_clk, timer_base_clk};
			src_s2_reg <= src_s1_reg;
			src_s3_reg <= src_s2_reg;
			cap_s1_reg <= {neighbour_match_in, lf_rx_data_out, ext_capture_pin};
			cap_s2_reg <= cap_s1_reg;
			cap_s3_reg <= cap_s2_reg;
		end
	end

	always_ff @(posedge clock_in)
	begin
		if (reset_in)
			src_level <= 8'h00;
		else if (clk_en_in)
		begin
			for (int i = 0; i < 8; i++)
				if (src_s2_reg[i] == src_s3_reg[i])
					src_level[i] <= src_s3_reg[i];
		end
	end

	// ==========================================
	// Counter clock tick: rising edge of selected source
	assign sel_s2 = src_s2_reg[mode_in.clk_sel];
	assign sel_s3 = src_s3_reg[mode_in.clk_sel];
	assign tick = ctrl_in.enable && sel_s2 && sel_s3 && !src_level[mode_in.clk_sel];

	// ==========================================
	// Capture source select and filter
	always_comb
	begin
		case (mode_in.cap_sel)
			sbcct_pkg::ICS_PIN: cap_raw = cap_s3_reg[0];
			sbcct_pkg::ICS_LF: cap_raw = cap_s3_reg[1];
			sbcct_pkg::ICS_T1: cap_raw = src_s3_reg[sbcct_pkg::CS_T1];
			sbcct_pkg::ICS_T2: cap_raw = src_s3_reg[sbcct_pkg::CS_T2];
			default: cap_raw = 1'b0;
		endcase
	end

	sbcct_filter u_filter (
		.clock_in(clock_in),
		.reset_in(reset_in),
		.enable_in(clk_en_in),
		.tick_in(tick),
		.filter_en_in(mode_in.filter_en),
		.edge_sel_in(mode_in.edge_sel),
		.sample_in(cap_raw),
		.event_out(cap_edge)
	);

	// ==========================================
	// Sensor start synchronised to counter tick
	// Start request waits for a tick so SM_RUN begins on a counter step; the count is not cleared
	always_ff @(posedge clock_in)
	begin
		if (reset_in)
			sm_reg <= sbcct_pkg::SM_IDLE;
		else if (clk_en_in)
		begin
			case (sm_reg)
				sbcct_pkg::SM_IDLE: if (sensor_meas_start_in) sm_reg <= sbcct_pkg::SM_ARMED;
				sbcct_pkg::SM_ARMED: if (tick) sm_reg <= sbcct_pkg::SM_RUN;
				sbcct_pkg::SM_RUN: if (!sensor_meas_start_in) sm_reg <= sbcct_pkg::SM_IDLE;
				default: sm_reg <= sbcct_pkg::SM_IDLE;
			endcase
		end
	end

	always_ff @(posedge clock_in)
	begin
		if (reset_in)
			sensor_busy_out <= 1'b0;
		else if (clk_en_in)
			sensor_busy_out <= sm_reg != sbcct_pkg::SM_IDLE;
	end

	assign capture_evt = cap_edge || (sw_capture_req_out && tick)
		|| (sm_reg == sbcct_pkg::SM_RUN && cap_s2_reg[2] && !cap_s3_reg[2]);

	// ==========================================
	// Compare, single action and alternate sequence
	assign match_a_sig = tick && counter_value_out == cmp_a_reg;
	assign match_b_sig = tick && counter_value_out == cmp_b_reg;
	assign fire_a = match_a_sig && !(action_in.single_mask_a && single_a_done_reg)
		&& (!ctrl_in.alt_compare_en || !alt_turn_reg);
	assign fire_b = match_b_sig && !(action_in.single_mask_b && single_b_done_reg)
		&& (!ctrl_in.alt_compare_en || alt_turn_reg);
	assign capture_reset_sig = capture_evt && action_in.capture_reset_mask;
	assign wrap = tick && counter_value_out == sbcct_pkg::CNT_MAX;
	assign start_pulse = ctrl_in.enable && !enable_prev_reg;

	always_ff @(posedge clock_in)
	begin
		if (reset_in)
		begin
			alt_turn_reg <= 1'b0;
			single_a_done_reg <= 1'b0;
			single_b_done_reg <= 1'b0;
			enable_prev_reg <= 1'b0;
		end
		else if (clk_en_in)
		begin
			enable_prev_reg <= ctrl_in.enable;
			if (start_pulse || !ctrl_in.alt_compare_en)
				alt_turn_reg <= 1'b0;
			else if (fire_a || fire_b)
				alt_turn_reg <= ~alt_turn_reg;
			if (start_pulse || !action_in.single_mask_a)
				single_a_done_reg <= 1'b0;
			else if (fire_a)
				single_a_done_reg <= 1'b1;
			if (start_pulse || !action_in.single_mask_b)
				single_b_done_reg <= 1'b0;
			else if (fire_b)
				single_b_done_reg <= 1'b1;
		end
	end

	// ==========================================
	// Counter
	always_ff @(posedge clock_in)
	begin
		if (reset_in)
			counter_value_out <= sbcct_pkg::CNT_RESET;
		else if (clk_en_in)
		begin
			if (ctrl_in.counter_reset || capture_reset_sig
				|| (fire_a && action_in.reset_mask_a) || (fire_b && action_in.reset_mask_b))
				counter_value_out <= sbcct_pkg::CNT_RESET;
			else if (tick)
				counter_value_out <= counter_value_out + 16'h0001;
		end
	end

	// ==========================================
	// Stage clock output follows counter tick
	always_ff @(posedge clock_in)
	begin
		if (reset_in)
			own_stage_clk_out <= 1'b0;
		else if (clk_en_in)
			own_stage_clk_out <= tick;
	end

	// ==========================================
	// Modulator output
	always_ff @(posedge clock_in)
	begin
		if (reset_in)
			modulator_out_pin_out <= 1'b0;
		else if (clk_en_in && modulator_en_in)
		begin
			if ((start_pulse && ctrl_in.toggle_on_start)
				^ (fire_a && action_in.toggle_mask_a) ^ (fire_b && action_in.toggle_mask_b))
				modulator_out_pin_out <= ~modulator_out_pin_out;
		end
	end

	// ==========================================
	// Capture register and software request
	always_ff @(posedge clock_in)
	begin
		if (reset_in)
			capture_reg <= sbcct_pkg::CNT_RESET;
		else if (clk_en_in && capture_evt)
			capture_reg <= counter_value_out;
	end

	always_ff @(posedge clock_in)
	begin
		if (reset_in)
			sw_capture_req_out <= 1'b0;
		else if (clk_en_in)
		begin
			if (sw_capture_set_in)
				sw_capture_req_out <= 1'b1;
			else if (tick)
				sw_capture_req_out <= 1'b0;
		end
	end

	// ==========================================
	// Byte access to 16-bit registers
	always_ff @(posedge clock_in)
	begin
		if (reset_in)
		begin
			cmp_a_reg <= sbcct_pkg::CNT_MAX;
			cmp_b_reg <= sbcct_pkg::CNT_MAX;
			hi_stage_reg <= 8'h00;
			hi_latch_reg <= 8'h00;
			byte_rdata_out <= 8'h00;
		end
		else if (clk_en_in)
		begin
			if (byte_wr_in && byte_hi_in)
				hi_stage_reg <= byte_wdata_in;
			else if (byte_wr_in && byte_sel_in == sbcct_pkg::SEL_CMP_A)
				cmp_a_reg <= {hi_stage_reg, byte_wdata_in};
			else if (byte_wr_in && byte_sel_in == sbcct_pkg::SEL_CMP_B)
				cmp_b_reg <= {hi_stage_reg, byte_wdata_in};
			if (byte_rd_in && byte_hi_in)
				byte_rdata_out <= hi_latch_reg;
			else if (byte_rd_in)
			begin
				case (byte_sel_in)
					sbcct_pkg::SEL_CMP_A:
					begin
						byte_rdata_out <= cmp_a_reg[7:0];
						hi_latch_reg <= cmp_a_reg[15:8];
					end
					sbcct_pkg::SEL_CMP_B:
					begin
						byte_rdata_out <= cmp_b_reg[7:0];
						hi_latch_reg <= cmp_b_reg[15:8];
					end
					sbcct_pkg::SEL_CAP:
					begin
						byte_rdata_out <= capture_reg[7:0];
						hi_latch_reg <= capture_reg[15:8];
					end
					default: byte_rdata_out <= 8'h00;
				endcase
			end
		end
	end

	// ==========================================
	// Interrupt flags, set wins over clear
	always_ff @(posedge clock_in)
	begin
		if (reset_in)
			irq_flag_reg_out <= 4'h0;
		else if (clk_en_in)
		begin
			irq_flag_reg_out <= (irq_flag_reg_out & ~irq_clear_in)
				| {capture_evt, fire_b, fire_a, wrap};
		end
	end

	always_ff @(posedge clock_in)
	begin
		if (reset_in)
		begin
			capture_irq_out <= 1'b0;
			overflow_irq_out <= 1'b0;
			match_a_irq_out <= 1'b0;
			match_b_irq_out <= 1'b0;
		end
		else if (clk_en_in)
		begin
			capture_irq_out <= irq_flag_reg_out[sbcct_pkg::IRQ_CAP] & irq_mask_reg_in[sbcct_pkg::IRQ_CAP];
			overflow_irq_out <= irq_flag_reg_out[sbcct_pkg::IRQ_OVF] & irq_mask_reg_in[sbcct_pkg::IRQ_OVF];
			match_a_irq_out <= irq_flag_reg_out[sbcct_pkg::IRQ_MA] & irq_mask_reg_in[sbcct_pkg::IRQ_MA];
			match_b_irq_out <= irq_flag_reg_out[sbcct_pkg::IRQ_MB] & irq_mask_reg_in[sbcct_pkg::IRQ_MB];
		end
	end

endmodule : sbcct_timer

// file: verif/sbcct_timer_asserts.sv
// Checker: port-level assertions for the capture/compare timer
module sbcct_timer_chk (
	input wire logic clock_in,
	input wire logic reset_in,
	input wire logic clk_en_in,
	input wire sbcct_pkg::sbcct_ctrl_t ctrl_in,
	input wire sbcct_pkg::sbcct_action_t action_in,
	input wire logic [3:0] irq_mask_reg_in,
	input wire logic [3:0] irq_clear_in,
	input wire logic sw_capture_set_in,
	input wire logic byte_rd_in,
	input wire logic [7:0] byte_rdata_out,
	input wire logic [15:0] counter_value_out,
	input wire logic sw_capture_req_out,
	input wire logic [3:0] irq_flag_reg_out,
	input wire logic capture_irq_out,
	input wire logic overflow_irq_out,
	input wire logic match_a_irq_out,
	input wire logic match_b_irq_out,
	input wire logic own_stage_clk_out
);
	// ==========================================
	// Assertions
	default clocking @(posedge clock_in); endclocking
	default disable iff (reset_in);
	a_irq_mask_gate: assert property ($past(clk_en_in)
		|-> {capture_irq_out, match_b_irq_out, match_a_irq_out, overflow_irq_out}
		== $past(irq_flag_reg_out & irq_mask_reg_in)) else $error("irq not flag and mask");
	// Frozen cycles hold the stage pulse, so only enabled cycles are judged
	a_count_step: assert property ($past(clk_en_in) && own_stage_clk_out
		|-> counter_value_out == $past(counter_value_out) + 16'h0001 || counter_value_out == 16'h0000)
		else $error("bad count step");
	a_count_hold: assert property (!own_stage_clk_out && !$past(ctrl_in.counter_reset)
		&& !$past(action_in.capture_reset_mask) |-> $stable(counter_value_out)) else $error("count moved");
	a_reset_clears: assert property (clk_en_in && ctrl_in.counter_reset
		|=> counter_value_out == 16'h0000) else $error("counter not cleared");
	a_stage_pulse: assert property (clk_en_in && own_stage_clk_out
		|=> !own_stage_clk_out) else $error("stage clock too long");
	a_ovf_cause: assert property ($rose(irq_flag_reg_out[0])
		|-> $past(counter_value_out) == 16'hFFFF) else $error("overflow without wrap");
	a_swcap_set: assert property (clk_en_in && sw_capture_set_in
		|=> sw_capture_req_out) else $error("capture request not set");
	a_swcap_flag: assert property ($fell(sw_capture_req_out)
		|-> ##[0:2] irq_flag_reg_out[3]) else $error("no capture flag");
	a_rdata_stands: assert property (!$past(byte_rd_in)
		|-> $stable(byte_rdata_out)) else $error("read data changed");
	a_flag_sticky: assert property ((~irq_flag_reg_out & $past(irq_flag_reg_out)
		& ~$past(irq_clear_in)) == 4'h0) else $error("flag dropped");
	c_tick: cover property (own_stage_clk_out);
	c_match_a: cover property ($rose(irq_flag_reg_out[1]));
	c_swcap: cover property ($fell(sw_capture_req_out));
endmodule : sbcct_timer_chk

bind sbcct_timer sbcct_timer_chk chk (.clock_in, .reset_in, .clk_en_in, .ctrl_in, .action_in, .irq_mask_reg_in,
	.irq_clear_in, .sw_capture_set_in, .byte_rd_in, .byte_rdata_out, .counter_value_out, .sw_capture_req_out,
	.irq_flag_reg_out, .capture_irq_out, .overflow_irq_out, .match_a_irq_out, .match_b_irq_out, .own_stage_clk_out);

// file: verif/sixteen_bit_capture_compare_timer_bench.sv
// Bench: self-checking test of the capture/compare timer
module sixteen_bit_capture_compare_timer_bench;
	timeunit 1ns;
	timeprecision 1ns;
	logic clock_in = 1'b0;
	logic reset_in = 1'b1;
	sbcct_pkg::sbcct_ctrl_t ctrl = '0;
	sbcct_pkg::sbcct_action_t act = '0;
	sbcct_pkg::sbcct_mode_t mode = '0;
	logic [3:0] imask = 4'h0;
	logic [3:0] iclr = 4'h0;
	logic swcap = 1'b0;
	logic bwr = 1'b0;
	logic brd = 1'b0;
	logic bhi = 1'b0;
	logic [1:0] bsel = 2'h0;
	logic [7:0] bwd = 8'h00;
	logic [7:0] src = 8'h00;
	logic pin = 1'b0;
	logic [7:0] rdata;
	logic [15:0] cnt;
	logic swreq;
	logic [3:0] flags;
	logic [3:0] irq;
	logic modo;
	logic busy;
	logic cke = 1'b1;
	logic sens = 1'b0;
	logic nbr = 1'b0;
	int bad_count = 0;
	int n_compared = 0;
	int cycles = 0;
	integer seed = 32'h5C2B9F7D;
	logic [15:0] cmp_m [2] = '{16'hFFFF, 16'hFFFF};
	int q_what [$];
	logic [15:0] q_val [$];

	// Tied inputs: LF data and modulator enable stay fixed
	sbcct_timer dut (.clock_in(clock_in), .reset_in(reset_in), .clk_en_in(cke), .ctrl_in(ctrl), .action_in(act),
		.mode_in(mode), .modulator_en_in(1'b1), .irq_mask_reg_in(imask), .irq_clear_in(iclr),
		.sw_capture_set_in(swcap), .byte_wr_in(bwr), .byte_rd_in(brd), .byte_hi_in(bhi), .byte_sel_in(bsel),
		.byte_wdata_in(bwd), .io_clk(src[1]), .ext_clk_in_a(src[5]), .ext_clk_in_b(src[6]),
		.timer_zero_stage_clk(src[2]), .timer_one_stage_clk(src[3]), .timer_two_stage_clk(src[4]),
		.rc_osc_out(src[7]), .timer_base_clk(src[0]), .ext_capture_pin(pin), .lf_rx_data_out(1'b0),
		.sensor_meas_start_in(sens), .neighbour_match_in(nbr), .byte_rdata_out(rdata), .counter_value_out(cnt),
		.sw_capture_req_out(swreq), .irq_flag_reg_out(flags), .capture_irq_out(irq[3]), .overflow_irq_out(irq[0]),
		.match_a_irq_out(irq[1]), .match_b_irq_out(irq[2]), .modulator_out_pin_out(modo),
		.own_stage_clk_out(), .sensor_busy_out(busy));

	always #5 clock_in = ~clock_in;

	// ==========================================
	// Checking
	function automatic logic [15:0] pick(input int w);
		case (w)
			0: return {8'h00, rdata};
			1: return cnt;
			2: return {15'h0000, flags[3]};
			3: return {12'h000, flags};
			4: return {12'h000, irq};
			5: return {15'h0000, modo};
			6: return {15'h0000, swreq};
			default: return {15'h0000, busy};
		endcase
	endfunction : pick

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
			bad_count++;
		end
	endtask : check

	task automatic summarize();
		$display("compared %0d, mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : summarize

	// Monitor pops at posedge what the driver noted at the negedge before
	always @(posedge clock_in)
	begin
		cycles <= cycles + 1;
		if (q_what.size() > 0)
			check(pick(q_what.pop_front()), q_val.pop_front());
		if (cycles >= 5000)
		begin
			bad_count++;
			summarize();
		end
	end

	// ==========================================
	// Drivers
	task automatic note(input int w, input logic [15:0] v);
		@(negedge clock_in);
		q_what.push_back(w);
		q_val.push_back(v);
		@(posedge clock_in);
	endtask : note

	// Source held 4 cycles each phase, above the 2-cycle minimum for a tick
	task automatic tick(input int n);
		repeat (n)
		begin
			src[mode.clk_sel] <= 1'b1;
			repeat (4) @(posedge clock_in);
			src[mode.clk_sel] <= 1'b0;
			repeat (4) @(posedge clock_in);
		end
		repeat (4) @(posedge clock_in);
	endtask : tick

	task automatic clr();
		iclr <= 4'hF;
		@(posedge clock_in);
		iclr <= 4'h0;
		@(posedge clock_in);
	endtask : clr

	task automatic start();
		ctrl.enable <= 1'b0;
		@(posedge clock_in);
		ctrl <= '{enable: 1'b1, counter_reset: 1'b1, toggle_on_start: 1'b0, alt_compare_en: ctrl.alt_compare_en};
		@(posedge clock_in);
		ctrl.counter_reset <= 1'b0;
		clr();
	endtask : start

	task automatic wr(input logic [1:0] s, input logic h, input logic [7:0] d);
		bsel <= s;
		bhi <= h;
		bwd <= d;
		bwr <= 1'b1;
		@(posedge clock_in);
		bwr <= 1'b0;
		@(posedge clock_in);
	endtask : wr

	task automatic rd16(input logic [1:0] s, input logic [15:0] e);
		for (int h = 0; h < 2; h++)
		begin
			bsel <= s;
			bhi <= h[0];
			brd <= 1'b1;
			@(posedge clock_in);
			brd <= 1'b0;
			note(0, {8'h00, h ? e[15:8] : e[7:0]});
		end
	endtask : rd16

	task automatic wr16(input logic [1:0] s, input logic [15:0] v);
		wr(s, 1'b1, v[15:8]);
		wr(s, 1'b0, v[7:0]);
	endtask : wr16

	// Neighbour match pulse, long enough for the three-stage sync
	task automatic pulse();
		nbr <= 1'b1;
		repeat (4) @(posedge clock_in);
		nbr <= 1'b0;
		repeat (4) @(posedge clock_in);
	endtask : pulse

	// ==========================================
	// Scenarios
	initial
	begin
		logic [15:0] d;
		repeat (3) @(posedge clock_in);
		reset_in <= 1'b0;
		note(1, 16'h0000);
		note(3, 16'h0000);
		note(5, 16'h0000);
		$display("test reset done");
		for (int s = 0; s < 2; s++)
		begin
			// Top bit set keeps random compares out of reach of short counts
			d = 16'($random(seed)) | 16'h8000;
			wr(s[1:0], 1'b1, d[15:8]);
			rd16(s[1:0], cmp_m[s]);
			wr(s[1:0], 1'b0, d[7:0]);
			rd16(s[1:0], d);
		end
		$display("test byte access done");
		for (int c = 0; c < 8; c++)
		begin
			mode.clk_sel <= c[2:0];
			start();
			tick(3);
			note(1, 16'h0003);
		end
		$display("test clock select done");
		wr16(2'h0, 16'h0004);
		act <= 7'h05;
		imask <= 4'hF;
		start();
		tick(9);
		note(1, 16'h0004);
		note(5, 16'h0001);
		note(3, 16'h0002);
		note(4, 16'h0002);
		imask <= 4'h0;
		@(posedge clock_in);
		note(4, 16'h0000);
		$display("test compare reset toggle done");
		act <= 7'h00;
		wr16(2'h0, 16'h0003);
		wr16(2'h1, 16'h0002);
		start();
		tick(5);
		note(3, 16'h0006);
		ctrl.alt_compare_en <= 1'b1;
		@(posedge clock_in);
		start();
		tick(5);
		note(3, 16'h0002);
		ctrl.alt_compare_en <= 1'b0;
		$display("test alternate done");
		// Compare B still matches at 2 and fires each time, together with A only the first time
		act <= 7'h06;
		wr16(2'h0, 16'h0002);
		start();
		tick(4);
		note(3, 16'h0006);
		clr();
		tick(6);
		note(3, 16'h0004);
		note(1, 16'h0007);
		act <= 7'h00;
		$display("test single action done");
		start();
		tick(3);
		swcap <= 1'b1;
		@(posedge clock_in);
		swcap <= 1'b0;
		note(6, 16'h0001);
		tick(1);
		note(6, 16'h0000);
		note(2, 16'h0001);
		rd16(2'h2, 16'h0003);
		$display("test software capture done");
		for (int e = 0; e < 4; e++)
		begin
			mode.edge_sel <= e[1:0];
			start();
			pin <= 1'b1;
			tick(3);
			note(2, {15'h0000, e[0]});
			clr();
			pin <= 1'b0;
			tick(3);
			note(2, {15'h0000, e[1]});
		end
		$display("test capture edges done");
		mode.filter_en <= 1'b1;
		start();
		pin <= 1'b1;
		tick(2);
		pin <= 1'b0;
		tick(6);
		note(2, 16'h0000);
		pin <= 1'b1;
		tick(6);
		note(2, 16'h0001);
		$display("test noise filter done");
		mode.filter_en <= 1'b1;
		act <= 7'h40;
		start();
		pulse();
		note(2, 16'h0000);
		sens <= 1'b1;
		tick(2);
		note(7, 16'h0001);
		pulse();
		note(2, 16'h0001);
		note(1, 16'h0000);
		sens <= 1'b0;
		rd16(2'h2, 16'h0002);
		note(7, 16'h0000);
		$display("test sensor done");
		cke <= 1'b0;
		tick(2);
		cke <= 1'b1;
		note(1, 16'h0000);
		tick(1);
		note(1, 16'h0001);
		$display("test clock enable done");
		summarize();
	end
endmodule : sixteen_bit_capture_compare_timer_bench
